// [src/oper_status_consts.svh]
`ifndef OPER_STATUS_CONSTS_SVH
`define OPER_STATUS_CONSTS_SVH

// Register width and reset values
`define OPER_WIDTH          16
`define OPER_ENABLE_RST     16'h0000
`define OPER_EVENT_RST      16'h0000
`define OPER_CFG_CHG_RST    1'b0

// Bit positions of the operation status word
`define OPER_BIT_CALIB      0
`define OPER_BIT_SELFTEST   1
`define OPER_BIT_SCAN       4
`define OPER_BIT_WAIT_TRIG  5
`define OPER_BIT_STORAGE    7
`define OPER_BIT_CFG_CHG    8
`define OPER_BIT_MEM_THR    9
`define OPER_BIT_LOCKED     10
`define OPER_BIT_SETTINGS   11
`define OPER_BIT_ERROR      13
`define OPER_BIT_BUSY       14

// Stored reading counter and threshold width
`define OPER_COUNT_WIDTH    17
`define OPER_THR_RST        17'h00000

`endif

// [src/oper_status_pkg.sv]
`include "oper_status_consts.svh"

package oper_status_pkg;

  // One status word
  typedef logic [`OPER_WIDTH-1:0] oper_word_t;

  // Stored reading count or threshold
  typedef logic [`OPER_COUNT_WIDTH-1:0] oper_count_t;

  // Source of a read answer
  typedef enum logic [2:0] {
    RSEL_COND  = 3'b001,
    RSEL_ENAB  = 3'b010,
    RSEL_EVENT = 3'b100
  } read_sel_t;

  // State of the event latch
  typedef struct packed {
    oper_word_t cond_prev;   // Condition seen one cycle ago
    oper_word_t event_bits;  // Sticky event bits
  } event_state_t;

  // State of the register set
  typedef struct packed {
    oper_word_t  enable;      // Enable mask
    oper_count_t threshold;   // Memory threshold
    logic        cfg_chg;     // Sticky configuration changed
    logic        thr_prev;    // Threshold compare one cycle ago
    oper_word_t  rd_data;     // Read answer
    logic        rd_valid;    // Read answer strobe
    logic        summary;     // Summary to status byte
  } oper_state_t;

endpackage

// [src/oper_event_latch.sv]
`include "oper_status_consts.svh"

module oper_event_latch (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // Sources
  input  wire oper_status_pkg::oper_word_t cond_bits,
  input  wire oper_status_pkg::oper_word_t event_pulses,
  // Clear by event query or clear status
  input  wire logic                        clear,
  // Latched events
  output oper_status_pkg::oper_word_t      event_bits
);

  oper_status_pkg::event_state_t s_q;  // Registered state
  oper_status_pkg::event_state_t s_d;  // Next state
  oper_status_pkg::oper_word_t   rise; // Newly risen condition bits

  // Rising edges of conditions plus one-shot events
  always_comb begin
    s_d = s_q;
    rise = (cond_bits & ~s_q.cond_prev) | event_pulses;
    s_d.cond_prev = cond_bits;
    // Set wins over a clear in the same cycle
    if (clear) begin
      s_d.event_bits = rise;
    end else begin
      s_d.event_bits = s_q.event_bits | rise;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q.cond_prev  <= `OPER_EVENT_RST;
      s_q.event_bits <= `OPER_EVENT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_bits = s_q.event_bits;

endmodule

// [src/oper_status_regs.sv]
// Summary of operation
// - condition register read-only, reads change nothing
// - bit 14 high during lengthy command
// - factory reset sets bit 8
// - bit 0 calibrating, bit 1 self-test
// - bit 4 scanning, bit 5 awaiting trigger
// - bit 7 set on storage detected
// - bit 8 set on scan list change
// - bit 10 high while locked
// - bit 13 high while error queue nonempty
// - enable register writable, readable, full 16 bits
// - event reaches summary only when enabled
// - reads return binary-weighted sixteen-bit value
// - enable has bits 9 and 11 events
// - bit 9 from count above threshold
// - event bits sticky until query or clear
`include "oper_status_consts.svh"

module oper_status_regs (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // Live instrument state
  input  wire logic                         calibrating,
  input  wire logic                         self_testing,
  input  wire logic                         scanning,
  input  wire logic                         wait_for_trigger_flag,
  input  wire logic                         storage_device_detected,
  input  wire logic                         locked,
  input  wire logic                         config_import_query,
  input  wire logic [7:0]                   error_queue_count,
  // One-cycle event pulses
  input  wire logic                         scan_list_changed,
  input  wire logic                         settings_changed,
  // Stored reading count
  input  wire oper_status_pkg::oper_count_t reading_count,
  // Remote commands, each a one-cycle strobe
  input  wire logic                         factory_reset,
  input  wire logic                         status_preset,
  input  wire logic                         clear_status,
  input  wire logic                         cond_query,
  input  wire logic                         enable_query,
  input  wire logic                         event_query,
  input  wire logic                         enable_write,
  input  wire oper_status_pkg::oper_word_t  enable_wdata,
  input  wire logic                         threshold_write,
  input  wire oper_status_pkg::oper_count_t threshold_wdata,
  // Answers
  output oper_status_pkg::oper_word_t       rd_data,
  output logic                              rd_valid,
  output oper_status_pkg::oper_word_t       condition,
  output logic                              oper_summary
);

  // Registered state and its next value
  oper_status_pkg::oper_state_t s_q;         // Registered state
  oper_status_pkg::oper_state_t s_d;         // Next state
  // Combinational helpers
  oper_status_pkg::oper_word_t  cond;        // Live condition word
  oper_status_pkg::oper_word_t  pulses;      // One-shot events
  oper_status_pkg::oper_word_t  event_bits;  // Latched events
  oper_status_pkg::read_sel_t   rsel;        // Selected read source
  logic                         thr_above;   // Count above threshold
  logic                         any_query;   // Any read this cycle

  // Word with one bit set at a position
  // Shared by the condition and pulse builders
  function automatic oper_status_pkg::oper_word_t bit_at(input int unsigned pos, input logic val);
    oper_status_pkg::oper_word_t w;
    w = '0;
    w[pos] = val;
    return w;
  endfunction

  // Live condition word; all other positions stay zero
  // Rebuilt every cycle from live inputs, so a read cannot disturb it
  always_comb begin
    cond = '0;
    // Levels straight from the instrument
    cond = cond | bit_at(`OPER_BIT_CALIB, calibrating);
    cond = cond | bit_at(`OPER_BIT_SELFTEST, self_testing);
    cond = cond | bit_at(`OPER_BIT_SCAN, scanning);
    cond = cond | bit_at(`OPER_BIT_WAIT_TRIG, wait_for_trigger_flag);
    cond = cond | bit_at(`OPER_BIT_STORAGE, storage_device_detected);
    // Only held bit: its sources are one-cycle strobes
    cond = cond | bit_at(`OPER_BIT_CFG_CHG, s_q.cfg_chg);
    // Lock level held by the instrument
    cond = cond | bit_at(`OPER_BIT_LOCKED, locked);
    // Queue depth reduced to a flag
    cond = cond | bit_at(`OPER_BIT_ERROR, error_queue_count != 8'h00);
    // Busy follows the long command for its whole length
    cond = cond | bit_at(`OPER_BIT_BUSY, config_import_query);
  end

  // Memory threshold compare
  // Count and threshold share one width, no extension needed
  // A level; only its rise becomes an event
  assign thr_above = reading_count > s_q.threshold;

  // Event-only sources on bits 9 and 11
  // No live condition behind them, so both enter the latch as pulses
  // Threshold pulse fires once per crossing, not every cycle above it
  always_comb begin
    pulses = '0;
    // Count crossed the threshold this cycle
    pulses = pulses | bit_at(`OPER_BIT_MEM_THR, thr_above & ~s_q.thr_prev);
    // Settings change strobe from the instrument
    pulses = pulses | bit_at(`OPER_BIT_SETTINGS, settings_changed);
  end

  // Sticky event register
  // Query or clear-status empties it; an edge in the same cycle still lands
  // Its output feeds both the summary and the event read
  oper_event_latch oper_event_latch_inst (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .cond_bits    (cond),
    .event_pulses (pulses),
    .clear        (event_query | clear_status),
    .event_bits   (event_bits)
  );

  // Read source, one query at a time by priority
  // Event query wins: it also clears, so its answer must not be lost
  always_comb begin
    if (event_query) begin
      // Events, answered before they clear
      rsel = oper_status_pkg::RSEL_EVENT;
    end else if (enable_query) begin
      // Enable mask
      rsel = oper_status_pkg::RSEL_ENAB;
    end else begin
      // Condition word, also the idle choice
      rsel = oper_status_pkg::RSEL_COND;
    end
  end

  // Any query loads the answer register and raises its strobe
  assign any_query = cond_query | enable_query | event_query;

  // Next state
  always_comb begin
    // Every field holds unless a branch below changes it
    s_d = s_q;
    s_d.thr_prev = thr_above;
    // Strobe is high only in the cycle after a query
    s_d.rd_valid = any_query;
    // Enable mask write, then preset overrides
    if (enable_write) begin
      // Whole word taken, any value from 0 to ffff
      s_d.enable = enable_wdata;
    end
    // Preset comes last so it beats a write in the same cycle
    if (status_preset) begin
      s_d.enable = `OPER_ENABLE_RST;
    end
    // Threshold setting
    if (threshold_write) begin
      s_d.threshold = threshold_wdata;
    end
    // Configuration changed: set wins over clear
    if (clear_status) begin
      s_d.cfg_chg = 1'b0;
    end
    // Either source sets; coming after the clear, a set beats it
    if (scan_list_changed) begin
      s_d.cfg_chg = 1'b1;
    end
    if (factory_reset) begin
      s_d.cfg_chg = 1'b1;
    end
    // Read answer; reading condition changes nothing
    // Without a query the last answer is held for the host
    if (any_query) begin
      // Select is always one of its three codes, so no default
      unique case (rsel)
        oper_status_pkg::RSEL_COND: begin
          // Live word as seen on the query edge
          s_d.rd_data = cond;
        end
        oper_status_pkg::RSEL_ENAB: begin
          // Mask as it stood before any write this cycle
          s_d.rd_data = s_q.enable;
        end
        oper_status_pkg::RSEL_EVENT: begin
          // Latched events before this query clears them
          s_d.rd_data = event_bits;
        end
      endcase
    end
    // Summary of enabled events
    // Registered, so it follows the events by one cycle
    s_d.summary = |(event_bits & s_q.enable);
  end

  // State register
  // Synchronous reset; a zero mask keeps the summary quiet until set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Every field named so none starts unknown
      s_q.enable    <= `OPER_ENABLE_RST;
      s_q.threshold <= `OPER_THR_RST;
      s_q.cfg_chg   <= `OPER_CFG_CHG_RST;
      s_q.thr_prev  <= 1'b0;
      s_q.rd_data   <= `OPER_EVENT_RST;
      s_q.rd_valid  <= 1'b0;
      s_q.summary   <= 1'b0;
    end else begin
      // Whole state in one register
      s_q <= s_d;
    end
  end

  // Outputs from flops, condition is live
  // Condition has no flop delay, so the instrument sees its status at once
  assign rd_data      = s_q.rd_data;
  assign rd_valid     = s_q.rd_valid;
  assign condition    = cond;
  assign oper_summary = s_q.summary;

endmodule

// [dv/oper_status_chk.sv]
module oper_status_chk (
  // Clock and reset
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  // Live state
  input wire logic                        calibrating,
  input wire logic                        self_testing,
  input wire logic                        scanning,
  input wire logic                        wait_for_trigger_flag,
  input wire logic                        storage_device_detected,
  input wire logic                        locked,
  input wire logic                        config_import_query,
  input wire logic [7:0]                  error_queue_count,
  // Strobes
  input wire logic                        scan_list_changed,
  input wire logic                        factory_reset,
  input wire logic                        status_preset,
  input wire logic                        cond_query,
  input wire logic                        enable_query,
  input wire logic                        event_query,
  // Answers
  input wire oper_status_pkg::oper_word_t rd_data,
  input wire oper_status_pkg::oper_word_t condition,
  input wire logic                        rd_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Condition read that wins priority
  sequence s_cond_rd;
    cond_query && !enable_query && !event_query;
  endsequence
  // Preset then enable read
  sequence s_preset_rd;
    status_preset ##1 (enable_query && !event_query);
  endsequence
  property p_busy; condition[14] == config_import_query; endproperty
  property p_cal; condition[1:0] == {self_testing, calibrating}; endproperty
  property p_scan; condition[5:4] == {wait_for_trigger_flag, scanning}; endproperty
  property p_store; condition[7] == storage_device_detected; endproperty
  property p_lock; condition[10] == locked; endproperty
  property p_err; condition[13] == (error_queue_count != 8'h00); endproperty
  property p_unused; (condition & 16'h9a4c) == 16'h0000; endproperty
  property p_cfg; (factory_reset || scan_list_changed) |=> condition[8]; endproperty
  property p_cond_rd; s_cond_rd |=> rd_valid && rd_data == $past(condition); endproperty
  property p_preset; s_preset_rd |=> rd_valid && rd_data == 16'h0000; endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  a_cal: assert property (p_cal) else $error("calibrate or self-test bit wrong");
  a_scan: assert property (p_scan) else $error("scan or trigger bit wrong");
  a_store: assert property (p_store) else $error("storage bit wrong");
  a_lock: assert property (p_lock) else $error("locked bit wrong");
  a_err: assert property (p_err) else $error("error bit wrong");
  a_unused: assert property (p_unused) else $error("unused bit set");
  a_cfg: assert property (p_cfg) else $error("config bit not set");
  a_cond_rd: assert property (p_cond_rd) else $error("condition read wrong");
  a_preset: assert property (p_preset) else $error("enable not cleared");
endmodule

// [dv/oper_status_regs_tb_top.sv]
module oper_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         sys_clk = 1'b0, rst_n = 1'b0;
  logic [7:0]                   lv = 8'h00;   // Live levels
  logic [9:0]                   st = 10'h000; // Strobes: rst,preset,clr,cq,nq,eq,ew,tw,scan,set
  oper_status_pkg::oper_word_t  enable_wdata = 16'h0000, rd_data, condition;
  oper_status_pkg::oper_count_t threshold_wdata = 17'h00000, reading_count = 17'h00000;
  logic                         rd_valid, oper_summary;
  int                           n_errors = 0, samples_checked = 0, cycles = 0;
  // Expected word for each live level bit
  oper_status_pkg::oper_word_t  tbl [8] = '{16'h0001, 16'h0002, 16'h0010, 16'h0020,
                                            16'h0080, 16'h0400, 16'h4000, 16'h2000};
  oper_status_regs oper_status_regs_inst (
    .sys_clk, .rst_n, .calibrating(lv[0]), .self_testing(lv[1]), .scanning(lv[2]),
    .wait_for_trigger_flag(lv[3]), .storage_device_detected(lv[4]), .locked(lv[5]),
    .config_import_query(lv[6]), .error_queue_count({6'h00, lv[7], lv[7]}),
    .scan_list_changed(st[8]), .settings_changed(st[9]), .reading_count,
    .factory_reset(st[0]), .status_preset(st[1]), .clear_status(st[2]), .cond_query(st[3]),
    .enable_query(st[4]), .event_query(st[5]), .enable_write(st[6]), .enable_wdata,
    .threshold_write(st[7]), .threshold_wdata, .rd_data, .rd_valid, .condition, .oper_summary);
  // Clock and hang limit
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input oper_status_pkg::oper_word_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobe, returns once the answer has landed
  task automatic pulse(input int b);
    @(posedge sys_clk) st[b] <= 1'b1;
    @(posedge sys_clk) st <= 10'h000;
    #1;
  endtask
  task automatic rd(input int b, input oper_status_pkg::oper_word_t exp);
    pulse(b);
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask
  task automatic wr(input oper_status_pkg::oper_word_t d);
    @(posedge sys_clk) enable_wdata <= d;
    pulse(6);
  endtask
  // Each live level alone, then all together
  task automatic t_cond();
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk) lv <= 8'h01 << k;
      rd(3, tbl[k]);
      chk(condition, tbl[k]);
    end
    @(posedge sys_clk) lv <= 8'hff;
    rd(3, 16'h64b3);
    rd(3, 16'h64b3);
    @(posedge sys_clk) lv <= 8'h00;
    pulse(2);
  endtask
  // Sticky config bit from reset command and scan list change
  task automatic t_cfg();
    pulse(0);
    rd(3, 16'h0100);
    pulse(2);
    rd(3, 16'h0000);
    pulse(8);
    rd(3, 16'h0100);
    pulse(2);
  endtask
  // Mask write, read back, preset
  task automatic t_enab();
    wr(16'hffff);
    rd(4, 16'hffff);
    wr(16'h0012);
    rd(4, 16'h0012);
    pulse(1);
    rd(4, 16'h0000);
    // Preset straight into an enable read, back to back
    wr(16'h00ff);
    @(posedge sys_clk) st[1] <= 1'b1;
    @(posedge sys_clk) st <= 10'h010;
    @(posedge sys_clk) st <= 10'h000;
    #1 chk({15'h0000, rd_valid}, 16'h0001);
    chk(rd_data, 16'h0000);
  endtask
  // Masked events into the summary, query clears
  task automatic t_event();
    wr(16'h0800);
    pulse(9);
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0000, oper_summary}, 16'h0001);
    rd(5, 16'h0800);
    rd(5, 16'h0000);
    chk({15'h0000, oper_summary}, 16'h0000);
    wr(16'h0000);
    pulse(9);
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0000, oper_summary}, 16'h0000);
    pulse(2);
    wr(16'h0200);
    @(posedge sys_clk) threshold_wdata <= 17'h00005;
    pulse(7);
    @(posedge sys_clk) reading_count <= 17'h00006;
    repeat (3) @(posedge sys_clk);
    #1 chk({15'h0000, oper_summary}, 16'h0001);
    pulse(2);
    @(posedge sys_clk);
    #1 chk({15'h0000, oper_summary}, 16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_cond();
    t_cfg();
    t_enab();
    t_event();
    tally_and_finish();
  end
endmodule
bind oper_status_regs oper_status_chk oper_status_chk_inst (
  .sys_clk, .rst_n, .calibrating, .self_testing, .scanning, .wait_for_trigger_flag,
  .storage_device_detected, .locked, .config_import_query, .error_queue_count, .scan_list_changed,
  .factory_reset, .status_preset, .cond_query, .enable_query, .event_query, .rd_data, .condition,
  .rd_valid);
